// ==== hw/sample_check_pkg.sv ====
// Constants, offsets and field layout of the input sample error checker.
// Assumes an 8-bit register port addressed by byte offsets.
package sample_check_pkg;

    localparam int SAMPLE_W = 16;
    localparam int NUM_SAMPLES = 4;
    localparam int NUM_PORTS = 2;

    // Register offsets
    localparam logic [7:0] ADDR_PATTERN_BASE = 8'h38;
    localparam logic [7:0] ADDR_PATTERN_LAST = 8'h3F;
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h40;
    localparam logic [7:0] ADDR_RISE_MASK_LO = 8'h41;
    localparam logic [7:0] ADDR_RISE_MASK_HI = 8'h42;
    localparam logic [7:0] ADDR_FALL_MASK_LO = 8'h43;
    localparam logic [7:0] ADDR_FALL_MASK_HI = 8'h44;

    // Control/status field positions
    localparam int BIT_COMPARE_EN = 7;
    localparam int BIT_ERR_DET_B = 6;
    localparam int BIT_ERR_DET_A = 5;
    localparam int BIT_AUTO_CLEAR = 3;
    localparam int BIT_FAIL_B = 2;
    localparam int BIT_FAIL_A = 1;
    localparam int BIT_PASS = 0;

    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic [SAMPLE_W-1:0] PATTERN_RESET = 16'h0000;
    localparam logic [3:0] AUTO_CLEAR_SETS = 4'h8;

    typedef logic [NUM_SAMPLES-1:0][SAMPLE_W-1:0] pattern_set_t;

    function automatic logic [SAMPLE_W-1:0] bit_errors(input logic [SAMPLE_W-1:0] sample,
                                                       input logic [SAMPLE_W-1:0] pattern);
        bit_errors = sample ^ pattern;
    endfunction : bit_errors

endpackage : sample_check_pkg

// ==== hw/sample_if.sv ====
// Carrier for synchronised input samples and data-clock edge strobes.
// Driven by the capture stage, read by the comparison logic, one clock.
`timescale 1ns/10ps
interface sample_if;
    import sample_check_pkg::*;
    logic                riseStb;
    logic                fallStb;
    logic [SAMPLE_W-1:0] dataA;
    logic [SAMPLE_W-1:0] dataB;

    modport src (output riseStb, output fallStb, output dataA, output dataB);
    modport dst (input riseStb, input fallStb, input dataA, input dataB);
endinterface : sample_if

// ==== hw/sample_capture.sv ====
// Synchronises the data clock and both data ports into clk_sys and marks clock edges.
// Assumes data is stable for at least two clk_sys periods around each data-clock edge.
`timescale 1ns/10ps
module sample_capture
    import sample_check_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                dataClkPin,
    input  wire logic [SAMPLE_W-1:0] dataAPin,
    input  wire logic [SAMPLE_W-1:0] dataBPin,
    sample_if.src                    smp
);
    logic                clkMeta_r;
    logic                clkSync_r;
    logic                clkPrev_r;
    logic [SAMPLE_W-1:0] aMeta_r;
    logic [SAMPLE_W-1:0] aSync_r;
    logic [SAMPLE_W-1:0] bMeta_r;
    logic [SAMPLE_W-1:0] bSync_r;

    // Data goes through the same two stages so it lines up with the detected edge
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clkMeta_r <= 1'b0;
            clkSync_r <= 1'b0;
            clkPrev_r <= 1'b0;
        end else begin
            clkMeta_r <= dataClkPin;
            clkSync_r <= clkMeta_r;
            clkPrev_r <= clkSync_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            aMeta_r <= 16'h0000;
            aSync_r <= 16'h0000;
            bMeta_r <= 16'h0000;
            bSync_r <= 16'h0000;
        end else begin
            aMeta_r <= dataAPin;
            aSync_r <= aMeta_r;
            bMeta_r <= dataBPin;
            bSync_r <= bMeta_r;
        end
    end

    assign smp.riseStb = clkSync_r & ~clkPrev_r; // R11
    assign smp.fallStb = ~clkSync_r & clkPrev_r; // R11
    assign smp.dataA   = aSync_r;
    assign smp.dataB   = bSync_r;

    chk_edge_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
        !(smp.riseStb && smp.fallStb))
        else $error("rising and falling strobes together");

endmodule : sample_capture

// ==== hw/port_error_accum.sv ====
// Collects per-bit mismatches of one port across a four-sample set.
// Assumes edge strobes and set phase come from the same clk_sys domain.
`timescale 1ns/10ps
module port_error_accum
    import sample_check_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                enable,
    input  wire logic                setPhase,
    input  wire logic                riseStb,
    input  wire logic                fallStb,
    input  wire logic [SAMPLE_W-1:0] data,
    input  pattern_set_t             patterns,
    output logic                     setFail,
    output logic [SAMPLE_W-1:0]      riseMask_r,
    output logic [SAMPLE_W-1:0]      fallMask_r
);
    logic [SAMPLE_W-1:0] riseAcc_r;
    logic [SAMPLE_W-1:0] fallAcc_r;
    logic [SAMPLE_W-1:0] riseErr;
    logic [SAMPLE_W-1:0] fallErr;
    logic                setEnd;

    // Samples 0/2 on rising edges, 1/3 on falling edges
    assign riseErr = bit_errors(data, patterns[{setPhase, 1'b0}]); // R11
    assign fallErr = bit_errors(data, patterns[{setPhase, 1'b1}]); // R11
    assign setEnd  = enable && fallStb && setPhase;
    assign setFail = (|riseAcc_r) || (|fallAcc_r) || (|fallErr);

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !enable || setEnd) begin
            riseAcc_r <= 16'h0000;
            fallAcc_r <= 16'h0000;
        end else begin
            if (riseStb) begin
                riseAcc_r <= riseAcc_r | riseErr;
            end
            if (fallStb) begin
                fallAcc_r <= fallAcc_r | fallErr;
            end
        end
    end

    // Masks show the last completed set only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            riseMask_r <= 16'h0000;
            fallMask_r <= 16'h0000;
        end else if (setEnd) begin
            riseMask_r <= riseAcc_r; // R8
            fallMask_r <= fallAcc_r | fallErr; // R9
        end
    end

    chk_mask_from_set: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
        setEnd |=> fallMask_r == ($past(fallAcc_r) | $past(fallErr)))
        else $error("falling mask not taken from finished set");

endmodule : port_error_accum

// ==== hw/input_sample_error_detector.sv ====
// Input sample error detector: compares both input ports against patterns.
// Assumes an 8-bit register port from the serial control logic on clk_sys,
// and a port select level from the same domain.
//
// Overview of operation
// R1: Compare enable bit runs detection; clear means no comparison; resets to zero.
// R2: Sticky flag reports an error in recent comparisons on port B.
// R3: Bit five sticky flag reports an error in recent comparisons on port A.
// R4: Auto-clear resets error status after eight passing sets; off after reset.
// R5: Port B fail flag follows the latest sample set on port B.
// R6: Port A fail flag follows the latest sample set on port A.
// R7: Pass flag set when the latest set matched on both ports.
// R8: Read-only 16-bit rising-edge error mask in two byte registers.
// R9: Read-only 16-bit falling-edge error mask in two byte registers.
// R10: Port select zero shows port A masks, one shows port B.
// R11: Samples 0 and 2 on rising edges, 1 and 3 on falling edges.
// R12: Four patterns held per port; port select picks which a write sets.
// R13: Error-detected flags stay set until auto-clear or software clears them.
// R14: Source repeats the programmed four-sample pattern aligned to data-clock edges.
`timescale 1ns/10ps
module input_sample_error_detector
    import sample_check_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                input_data_clock,
    input  wire logic [SAMPLE_W-1:0] portAData,
    input  wire logic [SAMPLE_W-1:0] portBData,
    input  wire logic                portSelect,
    input  wire logic [7:0]          regAddr,
    input  wire logic                regWrEn,
    input  wire logic [7:0]          regWrData,
    output logic [7:0]               regRdData
);
    sample_if smp ();

    pattern_set_t        pattern_r [NUM_PORTS];
    logic                compareEn_r;
    logic                autoClear_r;
    logic                errDetA_r;
    logic                errDetB_r;
    logic                failA_r;
    logic                failB_r;
    logic                pass_r;
    logic                setPhase_r;
    logic [3:0]          passCount_r;
    logic [3:0]          passCount_nxt;
    logic                setDone;
    logic                setFailA;
    logic                setFailB;
    logic                setPass;
    logic                autoClrHit;
    logic                ctrlWrite;
    logic                swClearA;
    logic                swClearB;
    logic [SAMPLE_W-1:0] riseMaskA;
    logic [SAMPLE_W-1:0] fallMaskA;
    logic [SAMPLE_W-1:0] riseMaskB;
    logic [SAMPLE_W-1:0] fallMaskB;
    logic [SAMPLE_W-1:0] riseSel;
    logic [SAMPLE_W-1:0] fallSel;
    logic [7:0]          rdValue;
    logic [2:0]          patIdx;

    // R14 is relied on here: the set phase only counts edges, it never hunts for alignment
    sample_capture u_capture (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .dataClkPin (input_data_clock),
        .dataAPin   (portAData),
        .dataBPin   (portBData),
        .smp        (smp)
    );

    port_error_accum u_accum_a (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .enable     (compareEn_r),
        .setPhase   (setPhase_r),
        .riseStb    (smp.riseStb),
        .fallStb    (smp.fallStb),
        .data       (smp.dataA),
        .patterns   (pattern_r[0]),
        .setFail    (setFailA),
        .riseMask_r (riseMaskA),
        .fallMask_r (fallMaskA)
    );

    port_error_accum u_accum_b (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .enable     (compareEn_r),
        .setPhase   (setPhase_r),
        .riseStb    (smp.riseStb),
        .fallStb    (smp.fallStb),
        .data       (smp.dataB),
        .patterns   (pattern_r[1]),
        .setFail    (setFailB),
        .riseMask_r (riseMaskB),
        .fallMask_r (fallMaskB)
    );

    assign ctrlWrite  = regWrEn && (regAddr == ADDR_CTRL_STATUS);
    assign swClearA   = ctrlWrite && regWrData[BIT_ERR_DET_A];
    assign swClearB   = ctrlWrite && regWrData[BIT_ERR_DET_B];
    assign setDone    = compareEn_r && smp.fallStb && setPhase_r; // R1
    assign setPass    = !setFailA && !setFailB;
    assign autoClrHit = autoClear_r && setDone && setPass
                        && (passCount_r == AUTO_CLEAR_SETS - 4'h1);
    assign patIdx     = 3'(regAddr - ADDR_PATTERN_BASE);

    // Set phase: first rising edge after enable is sample 0
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !compareEn_r) begin
            setPhase_r <= 1'b0; // R1
        end else if (smp.fallStb) begin
            setPhase_r <= ~setPhase_r; // R11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            compareEn_r <= CTRL_STATUS_RESET[BIT_COMPARE_EN]; // R1
            autoClear_r <= CTRL_STATUS_RESET[BIT_AUTO_CLEAR]; // R4
        end else if (ctrlWrite) begin
            compareEn_r <= regWrData[BIT_COMPARE_EN]; // R1
            autoClear_r <= regWrData[BIT_AUTO_CLEAR]; // R4
        end
    end

    // R12
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int s = 0; s < NUM_SAMPLES; s++) begin
                    pattern_r[p][s] <= PATTERN_RESET;
                end
            end
        end else if (regWrEn && regAddr >= ADDR_PATTERN_BASE && regAddr <= ADDR_PATTERN_LAST) begin
            if (patIdx[0]) begin
                pattern_r[portSelect][patIdx[2:1]][15:8] <= regWrData; // R12
            end else begin
                pattern_r[portSelect][patIdx[2:1]][7:0] <= regWrData; // R12
            end
        end
    end

    // Fail and pass reflect the last set only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            failA_r <= CTRL_STATUS_RESET[BIT_FAIL_A];
            failB_r <= CTRL_STATUS_RESET[BIT_FAIL_B];
            pass_r  <= CTRL_STATUS_RESET[BIT_PASS];
        end else if (setDone) begin
            failA_r <= setFailA; // R6
            failB_r <= setFailB; // R5
            pass_r  <= setPass; // R7
        end
    end

    // Consecutive passing sets; any failure restarts the count
    always_comb begin
        passCount_nxt = passCount_r;
        if (!autoClear_r || (setDone && !setPass) || autoClrHit) begin
            passCount_nxt = 4'h0;
        end else if (setDone) begin
            passCount_nxt = passCount_r + 4'h1; // R4
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            passCount_r <= 4'h0;
        end else begin
            passCount_r <= passCount_nxt;
        end
    end

    // A new failure in the clearing cycle wins over any clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            errDetA_r <= CTRL_STATUS_RESET[BIT_ERR_DET_A];
        end else if (setDone && setFailA) begin
            errDetA_r <= 1'b1; // R3
        end else if (swClearA || autoClrHit) begin
            errDetA_r <= 1'b0; // R13
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            errDetB_r <= CTRL_STATUS_RESET[BIT_ERR_DET_B];
        end else if (setDone && setFailB) begin
            errDetB_r <= 1'b1; // R2
        end else if (swClearB || autoClrHit) begin
            errDetB_r <= 1'b0; // R13
        end
    end

    assign riseSel = portSelect ? riseMaskB : riseMaskA; // R10
    assign fallSel = portSelect ? fallMaskB : fallMaskA; // R10

    always_comb begin
        rdValue = 8'h00;
        if (regAddr >= ADDR_PATTERN_BASE && regAddr <= ADDR_PATTERN_LAST) begin
            rdValue = patIdx[0] ? pattern_r[portSelect][patIdx[2:1]][15:8]
                                : pattern_r[portSelect][patIdx[2:1]][7:0];
        end else begin
            unique case (regAddr)
                ADDR_CTRL_STATUS: begin
                    rdValue[BIT_COMPARE_EN] = compareEn_r;
                    rdValue[BIT_ERR_DET_B]  = errDetB_r;
                    rdValue[BIT_ERR_DET_A]  = errDetA_r;
                    rdValue[BIT_AUTO_CLEAR] = autoClear_r;
                    rdValue[BIT_FAIL_B]     = failB_r;
                    rdValue[BIT_FAIL_A]     = failA_r;
                    rdValue[BIT_PASS]       = pass_r;
                end
                ADDR_RISE_MASK_LO: rdValue = riseSel[7:0]; // R8
                ADDR_RISE_MASK_HI: rdValue = riseSel[15:8]; // R8
                ADDR_FALL_MASK_LO: rdValue = fallSel[7:0]; // R9
                ADDR_FALL_MASK_HI: rdValue = fallSel[15:8]; // R9
                default:           rdValue = 8'h00;
            endcase
        end
    end

    // Registered read data, one cycle behind the address
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= rdValue;
        end
    end

    sequence failing_set_b;
        setDone && setFailB;
    endsequence

    sequence failing_set_a;
        setDone && setFailA;
    endsequence

    chk_no_compare_off: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
        !compareEn_r |-> !setDone ##1 (setPhase_r == 1'b0))
        else $error("comparison ran while disabled");

    chk_err_b_sets: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
        failing_set_b |=> errDetB_r && failB_r)
        else $error("port B error not flagged");

    chk_err_a_sets: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
        failing_set_a |=> errDetA_r && failA_r && !pass_r)
        else $error("port A error not flagged");

    chk_auto_clear_eight: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
        autoClear_r && setDone && setPass && passCount_r == AUTO_CLEAR_SETS - 4'h1
        |=> !errDetA_r && !errDetB_r)
        else $error("auto-clear missed after eight passing sets");

    chk_fail_b_track: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
        setDone |=> failB_r == $past(setFailB))
        else $error("port B fail flag wrong");

    chk_fail_a_track: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
        setDone |=> failA_r == $past(setFailA))
        else $error("port A fail flag wrong");

    chk_pass_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
        setDone |=> pass_r == !((|riseMaskA) || (|fallMaskA) || (|riseMaskB) || (|fallMaskB)))
        else $error("pass flag disagrees with error masks");

    chk_rise_mask_read: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
        regAddr == ADDR_RISE_MASK_LO && !portSelect |=> regRdData == $past(riseMaskA[7:0]))
        else $error("rising mask read shows wrong port");

    chk_fall_mask_read: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
        regAddr == ADDR_FALL_MASK_HI && portSelect |=> regRdData == $past(fallMaskB[15:8]))
        else $error("falling mask read shows wrong port");

    chk_sticky_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
        errDetA_r && !swClearA && !autoClrHit |=> errDetA_r)
        else $error("port A error flag dropped without a clear");

    chk_pattern_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
        regWrEn && regAddr == ADDR_PATTERN_BASE |=> pattern_r[$past(portSelect)][0][7:0]
                                                    == $past(regWrData))
        else $error("pattern write not stored for selected port");

endmodule : input_sample_error_detector

// ==== testbench/sample_source.sv ====
// Behavioural data source at the far side of the two sample ports.
// Assumes the caller sets patterns and error masks before each run.
`timescale 1ns/10ps
module sample_source
    import sample_check_pkg::*;
(
    input  pattern_set_t        patA,
    input  pattern_set_t        patB,
    input  pattern_set_t        injA,
    input  pattern_set_t        injB,
    output logic                dataClk,
    output logic [SAMPLE_W-1:0] dataA,
    output logic [SAMPLE_W-1:0] dataB
);
    localparam int HALF_NS = 160;

    initial begin
        dataClk = 1'b0;
        dataA = 16'h0000;
        dataB = 16'hFFFF;
    end

    // Clock stands still low between frames, so every run starts on a rise
    task automatic run(input int sets);
        for (int n = 0; n < sets; n++) begin
            for (int s = 0; s < NUM_SAMPLES; s++) begin
                dataA = patA[s] ^ injA[s];
                dataB = patB[s] ^ injB[s];
                #(HALF_NS / 2);
                dataClk = ~dataClk;
                #(HALF_NS / 2);
            end
        end
        // Lines no longer qualified: show a changed value, not the last one
        dataA = ~dataA;
        dataB = ~dataB;
    endtask : run
endmodule : sample_source

// ==== testbench/input_sample_error_detector_tb.sv ====
// Self-checking bench for the input sample error detector.
// Assumes the register port and port select share clk_sys with the bench.
`timescale 1ns/10ps
`define CHK(name, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected %s expected %h seen %h", name, exp, got); \
        end \
    end
module input_sample_error_detector_tb;
    import sample_check_pkg::*;
    localparam int PERIOD_NS = 40;
    logic                clk_sys;
    logic                rst_b;
    logic                portSelect;
    logic                regWrEn;
    logic [7:0]          regAddr;
    logic [7:0]          regWrData;
    logic [7:0]          regRdData;
    logic                rdReq;
    logic                rdPend;
    logic                dataClk;
    logic [SAMPLE_W-1:0] dataA;
    logic [SAMPLE_W-1:0] dataB;
    pattern_set_t        patA;
    pattern_set_t        patB;
    pattern_set_t        injA;
    pattern_set_t        injB;
    logic [31:0]         seed;
    logic [7:0]          b;
    logic [7:0]          eVal;
    string               eName;
    logic [7:0]          expQ[$];
    string               nameQ[$];
    int                  mismatches;
    int                  samples_checked;

    input_sample_error_detector dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .input_data_clock(dataClk),
        .portAData(dataA), .portBData(dataB), .portSelect(portSelect),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData)
    );
    sample_source src (
        .patA(patA), .patB(patB), .injA(injA), .injB(injB),
        .dataClk(dataClk), .dataA(dataA), .dataB(dataB)
    );

    initial begin
        clk_sys = 1'b0;
        forever #(PERIOD_NS / 2) clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    function automatic logic [SAMPLE_W-1:0] one_bit();
        return 16'h0001 << (next_rand() % 32'd16);
    endfunction : one_bit

    task automatic wr(input logic sel, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        portSelect = sel;
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        rdReq = 1'b0;
    endtask : wr

    task automatic rd(input logic sel, input logic [7:0] addr, input logic [7:0] exp,
                      input string name);
        @(negedge clk_sys);
        portSelect = sel;
        regAddr = addr;
        regWrEn = 1'b0;
        rdReq = 1'b1;
        expQ.push_back(exp);
        nameQ.push_back(name);
    endtask : rd

    task automatic idle();
        @(negedge clk_sys);
        regWrEn = 1'b0;
        rdReq = 1'b0;
    endtask : idle

    // Fixed settle after the last fall: flags land on the third clk_sys rising edge after it
    task automatic run_sets(input int n);
        idle();
        src.run(n);
        repeat (8) @(negedge clk_sys);
    endtask : run_sets

    task automatic chk_masks(input logic sel, input pattern_set_t inj);
        logic [SAMPLE_W-1:0] rise;
        logic [SAMPLE_W-1:0] fall;
        rise = inj[0] | inj[2];
        fall = inj[1] | inj[3];
        rd(sel, ADDR_RISE_MASK_LO, rise[7:0], "rising mask low");
        rd(sel, ADDR_RISE_MASK_HI, rise[15:8], "rising mask high");
        rd(sel, ADDR_FALL_MASK_LO, fall[7:0], "falling mask low");
        rd(sel, ADDR_FALL_MASK_HI, fall[15:8], "falling mask high");
    endtask : chk_masks

    // Result of a read stands one cycle after its address edge
    always @(posedge clk_sys) rdPend <= rdReq;
    always @(negedge clk_sys) begin
        if (rdPend === 1'b1) begin
            eVal = expQ.pop_front();
            eName = nameQ.pop_front();
            `CHK(eName, eVal, regRdData)
        end
    end

    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        #200000;
        mismatches++;
        final_report();
    end

    initial begin
        rst_b = 1'b0;
        portSelect = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        rdReq = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        seed = 32'd66;
        patA = '0;
        patB = '0;
        injA = '0;
        injB = '0;
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int a = 8'h38; a <= 8'h44; a++) begin
                rd(p[0], 8'(a), 8'h00, "reset value");
            end
        end
        rd(1'b0, 8'h45, 8'h00, "unmapped read");
        wr(1'b0, ADDR_RISE_MASK_LO, 8'hFF);
        rd(1'b0, ADDR_RISE_MASK_LO, 8'h00, "read-only mask");
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int a = 0; a < 8; a++) begin
                b = 8'(next_rand());
                if (p == 0) patA[a / 2][(a % 2) * 8 +: 8] = b;
                else patB[a / 2][(a % 2) * 8 +: 8] = b;
                wr(p[0], ADDR_PATTERN_BASE + 8'(a), b);
                rd(p[0], ADDR_PATTERN_BASE + 8'(a), b, "pattern readback");
            end
        end
        injA[1] = one_bit();
        run_sets(1);
        rd(1'b0, ADDR_CTRL_STATUS, 8'h00, "status while disabled");
        injA = '0;
        wr(1'b0, ADDR_CTRL_STATUS, 8'h80);
        run_sets(1);
        rd(1'b0, ADDR_CTRL_STATUS, 8'h81, "status clean set");
        injA[0] = one_bit();
        injA[2] = one_bit();
        injA[3] = one_bit();
        run_sets(1);
        rd(1'b0, ADDR_CTRL_STATUS, 8'hA2, "status port A fail");
        chk_masks(1'b0, injA);
        chk_masks(1'b1, '0);
        injA = '0;
        injB[1] = one_bit();
        injB[2] = one_bit();
        run_sets(1);
        rd(1'b1, ADDR_CTRL_STATUS, 8'hE4, "status port B fail");
        chk_masks(1'b1, injB);
        chk_masks(1'b0, '0);
        injB = '0;
        run_sets(1);
        rd(1'b0, ADDR_CTRL_STATUS, 8'hE1, "sticky after clean set");
        wr(1'b0, ADDR_CTRL_STATUS, 8'hA0);
        rd(1'b0, ADDR_CTRL_STATUS, 8'hC1, "clear port A flag");
        wr(1'b0, ADDR_CTRL_STATUS, 8'hC0);
        rd(1'b0, ADDR_CTRL_STATUS, 8'h81, "clear port B flag");
        injA[2] = one_bit();
        run_sets(1);
        injA = '0;
        wr(1'b0, ADDR_CTRL_STATUS, 8'h88);
        run_sets(7);
        rd(1'b0, ADDR_CTRL_STATUS, 8'hA9, "flag before eighth set");
        run_sets(1);
        rd(1'b0, ADDR_CTRL_STATUS, 8'h89, "auto-clear after eight sets");
        idle();
        repeat (3) @(negedge clk_sys);
        final_report();
    end
endmodule : input_sample_error_detector_tb
